/* File: hw/hppr_pkg.sv */
// Package for the hub port power, role swap, serial ROM pin and attach control block
package hppr_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_DN_PORTS = 7;
  localparam int NUM_ATTACH   = 4;
  localparam int SYNC_STAGES  = 2;

  // ****************************************
  // Values after reset
  // ****************************************
  localparam logic       RST_ROLE_SWAP  = 1'h0;
  localparam logic       RST_ROM_CS_N   = 1'h1;
  localparam logic [6:0] RST_PORT_OC    = 7'h00;
  localparam logic [3:0] RST_PHY_EN     = 4'h0;
  localparam logic [1:0] RST_SYNC       = 2'h0;
  // Synchroniser presets {pins, attach, gang, swap}: pins and gang idle high, rest idle low
  localparam logic [12:0] RST_SYNC_IN   = 13'h1FC2;

  // Role state of the port 0 / port 1 pair
  typedef enum logic {
    HPPR_ROLE_DEFAULT,
    HPPR_ROLE_SWAPPED
  } hppr_role_t;

  // Pin triple for a two-way pin; oe_n low while the block drives
  typedef struct packed {
    logic o;
    logic oe_n;
    logic pu_en;
  } hppr_pin_t;

  // Serial ROM pin control from the core
  typedef struct packed {
    logic cs_n;
    logic clk;
    logic dout;
    logic active;
  } hppr_rom_t;

endpackage : hppr_pkg

/* File: hw/hppr_top.sv */
// Port power / overcurrent, role swap, serial ROM pin and PHY attach control
`timescale 1ns/1ps

// Function
// RL1 - Enabled downstream port: power pin is input with pull-up on, powering port.
// RL2 - Enabled port: low on power pin means overcurrent from external monitor.
// RL3 - Disabled port, by configuration or host: power pin driven low as output.
// RL4 - Ganged mode: one gang input acts as power pin for all ports.
// RL5 - Role-swap input low: port 0 upstream, port 1 downstream.
// RL6 - Role-swap input high: port 0 downstream, port 1 upstream.
// RL7 - Role-swap indicator shows 0 in default, 1 in swapped operation.
// RL8 - ROM chip select active low; held high in power-down when ROM enabled.
// RL9 - ROM disabled by utility config bit: ROM clock pin becomes general I/O.
// RL10 - ROM enabled: ROM clock pin held low throughout reset.
// RL11 - Without ROM, its pins are handled by their alternate functions, never floated.
// RL12 - Attach input 1 turns that port's SuperSpeed PHY on, 0 turns it off.
// RL13 - Legacy connectors: board ties attach inputs high, PHYs always on.
// RL14 - Overcurrent, gang, role-swap and attach inputs are synchronised first.
module hppr_top
  import hppr_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clock,
  input  wire logic                    i_nrst,
  // Port power configuration
  input  wire logic [NUM_DN_PORTS-1:0] i_port_enable,
  input  wire logic                    i_ganged_mode,
  // Port power / overcurrent pins
  input  wire logic [NUM_DN_PORTS-1:0] i_port_power_oc_pin,
  output logic      [NUM_DN_PORTS-1:0] o_port_power_oc_pin,
  output logic      [NUM_DN_PORTS-1:0] o_port_power_oc_pin_oe_n,
  output logic      [NUM_DN_PORTS-1:0] o_port_power_oc_pin_pu_en,
  output logic      [NUM_DN_PORTS-1:0] o_port_overcurrent,
  // Ganged power input
  input  wire logic                    i_ganged_power_input,
  output logic                         o_gang_overcurrent,
  // Role swap
  input  wire logic                    i_role_swap_input,
  output logic                         o_role_swap_indicator,
  output logic                         o_port0_upstream,
  output logic                         o_port1_upstream,
  // Serial ROM
  input  wire logic                    i_rom_disable,
  input  wire logic                    i_power_down,
  input  wire hppr_rom_t               i_rom_core,
  output logic                         o_rom_cs_n,
  output logic                         o_rom_clk,
  output logic                         o_rom_clk_oe_n,
  input  wire logic                    i_rom_clk_pin,
  input  wire logic                    i_gpio_out,
  input  wire logic                    i_gpio_oe,
  output logic                         o_general_io_four,
  output logic                         o_rom_dout,
  // Connector attach
  input  wire logic [NUM_ATTACH-1:0]   i_attach,
  output logic      [NUM_ATTACH-1:0]   o_phy_enable
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync <= RST_SYNC;
    end else begin
      rst_sync <= {rst_sync[0], 1'h1};
    end
  end
  assign rst_n = rst_sync[1];

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam int SYNC_W = NUM_DN_PORTS + NUM_ATTACH + 2;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_ff1;
  logic [SYNC_W-1:0] sync_ff2;

  assign sync_raw = {i_port_power_oc_pin, i_attach, i_ganged_power_input, i_role_swap_input};

  // Presets follow each input's idle level: no false fault, swap or attach after release
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff1 <= RST_SYNC_IN;
      sync_ff2 <= RST_SYNC_IN;
    end else begin
      sync_ff1 <= sync_raw;  // [RL14]
      sync_ff2 <= sync_ff1;  // [RL14]
    end
  end

  logic [NUM_DN_PORTS-1:0] pin_s;
  logic [NUM_ATTACH-1:0]   attach_s;
  logic                    gang_s;
  logic                    swap_s;

  assign {pin_s, attach_s, gang_s, swap_s} = sync_ff2;

  // ****************************************
  // Port power pins
  // ****************************************
  // Ganged mode needs at least one enabled port to power the shared switch
  logic gang_on;
  assign gang_on = |i_port_enable;

  logic [NUM_DN_PORTS-1:0] next_port_overcurrent;

  genvar g;
  generate
    for (g = 0; g < NUM_DN_PORTS; g++) begin : g_port
      logic en;
      assign en = i_ganged_mode ? gang_on : i_port_enable[g];
      // Open drain: only ever drives low; released with pull-up when enabled
      assign o_port_power_oc_pin[g]       = 1'h0;                  // [RL3]
      assign o_port_power_oc_pin_oe_n[g]  = en;                    // [RL1] [RL3]
      assign o_port_power_oc_pin_pu_en[g] = en;                    // [RL1]
      // Ganged ports share the sense of the gang input
      assign next_port_overcurrent[g] = en & ~(i_ganged_mode ? gang_s : pin_s[g]); // [RL2] [RL4]
    end
  endgenerate

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_port_overcurrent <= RST_PORT_OC;
    end else begin
      o_port_overcurrent <= next_port_overcurrent;  // [RL2]
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_gang_overcurrent <= 1'h0;
    end else begin
      o_gang_overcurrent <= i_ganged_mode & gang_on & ~gang_s;  // [RL4]
    end
  end

  // ****************************************
  // Role swap
  // ****************************************
  hppr_role_t role;

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      role <= HPPR_ROLE_DEFAULT;
    end else begin
      role <= swap_s ? HPPR_ROLE_SWAPPED : HPPR_ROLE_DEFAULT;  // [RL5] [RL6]
    end
  end

  always_comb begin
    case (role)
      HPPR_ROLE_DEFAULT: begin
        o_role_swap_indicator = 1'h0;  // [RL7]
        o_port0_upstream      = 1'h1;  // [RL5]
        o_port1_upstream      = 1'h0;
      end
      HPPR_ROLE_SWAPPED: begin
        o_role_swap_indicator = 1'h1;  // [RL7]
        o_port0_upstream      = 1'h0;  // [RL6]
        o_port1_upstream      = 1'h1;
      end
      default: begin
        o_role_swap_indicator = 1'h0;
        o_port0_upstream      = 1'h1;
        o_port1_upstream      = 1'h0;
      end
    endcase
  end

  // ****************************************
  // Serial ROM pins
  // ****************************************
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rom_cs_n <= RST_ROM_CS_N;
      o_rom_clk  <= 1'h0;           // [RL10]
      o_rom_dout <= 1'h0;
      o_general_io_four <= 1'h0;
    end else begin
      // Power-down overrides any core request so the ROM stays deselected
      o_rom_cs_n <= i_rom_disable | i_power_down | i_rom_core.cs_n;  // [RL8]
      o_rom_clk  <= i_rom_disable ? i_gpio_out
                  : (i_power_down ? 1'h0 : i_rom_core.clk);          // [RL9]
      o_rom_dout <= i_rom_disable ? 1'h0 : i_rom_core.dout;
      o_general_io_four <= i_rom_clk_pin;                            // [RL9]
    end
  end

  // Clock pin driven whenever the ROM is in use; held during reset too
  assign o_rom_clk_oe_n = !rst_n ? 1'h0                              // [RL10]
                        : (i_rom_disable ? ~i_gpio_oe : 1'h0);       // [RL9] [RL11]

  // ****************************************
  // SuperSpeed PHY enables
  // ****************************************
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_phy_enable <= RST_PHY_EN;
    end else begin
      o_phy_enable <= attach_s;  // [RL12] [RL13]
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_attach_held;
    i_attach[0][*3];
  endsequence

  sequence s_attach_idle;
    (!i_attach[0])[*3];
  endsequence

  property p_disabled_drives_low;
    @(posedge i_clock) disable iff (!rst_n)
      (!i_ganged_mode && !i_port_enable[0]) |-> (!o_port_power_oc_pin_oe_n[0] &&
        !o_port_power_oc_pin[0]);
  endproperty
  a_disabled_drives_low: assert property (p_disabled_drives_low)  // [RL3]
    else $error("disabled port pin not driven low");

  property p_enabled_pullup;
    @(posedge i_clock) disable iff (!rst_n)
      (!i_ganged_mode && i_port_enable[1]) |-> (o_port_power_oc_pin_oe_n[1] &&
        o_port_power_oc_pin_pu_en[1]);
  endproperty
  a_enabled_pullup: assert property (p_enabled_pullup)  // [RL1]
    else $error("enabled port pin not released with pull-up");

  property p_oc_flag;
    @(posedge i_clock) disable iff (!rst_n)
      (!i_ganged_mode && i_port_enable[2] && !i_port_power_oc_pin[2])[*1] ##1
      (!i_ganged_mode && i_port_enable[2]) ##1 (!i_ganged_mode && i_port_enable[2])
      |=> o_port_overcurrent[2];
  endproperty
  a_oc_flag: assert property (p_oc_flag)  // [RL2]
    else $error("overcurrent not flagged three cycles after low pin");

  property p_gang_oc;
    @(posedge i_clock) disable iff (!rst_n)
      (i_ganged_mode && gang_on && !gang_s) |=> o_port_overcurrent[0];
  endproperty
  a_gang_oc: assert property (p_gang_oc)  // [RL4]
    else $error("ganged overcurrent not shared by port 0");

  property p_role_follow;
    @(posedge i_clock) disable iff (!rst_n)
      $changed(swap_s) |=> (o_role_swap_indicator == $past(swap_s));
  endproperty
  a_role_follow: assert property (p_role_follow)  // [RL7]
    else $error("role indicator did not follow swap input");

  property p_role_ports;
    @(posedge i_clock) disable iff (!rst_n)
      o_port0_upstream == !o_role_swap_indicator && o_port1_upstream == o_role_swap_indicator;
  endproperty
  a_role_ports: assert property (p_role_ports)  // [RL5] [RL6]
    else $error("upstream port does not match role state");

  property p_cs_power_down;
    @(posedge i_clock) disable iff (!rst_n)
      i_power_down |=> o_rom_cs_n;
  endproperty
  a_cs_power_down: assert property (p_cs_power_down)  // [RL8]
    else $error("ROM select low in power-down");

  property p_rom_clk_reset;
    @(posedge i_clock) !rst_n |-> (!o_rom_clk && !o_rom_clk_oe_n);
  endproperty
  a_rom_clk_reset: assert property (p_rom_clk_reset)  // [RL10]
    else $error("ROM clock not driven low in reset");

  property p_gpio_takeover;
    @(posedge i_clock) disable iff (!rst_n)
      i_rom_disable |-> (o_rom_clk_oe_n == !i_gpio_oe);
  endproperty
  a_gpio_takeover: assert property (p_gpio_takeover)  // [RL9]
    else $error("ROM clock pin not handed to general I/O");

  property p_phy_attach;
    @(posedge i_clock) disable iff (!rst_n)
      s_attach_held |=> o_phy_enable[0];
  endproperty
  a_phy_attach: assert property (p_phy_attach)  // [RL12] [RL14]
    else $error("PHY 0 not enabled after attach");

  property p_phy_detach;
    @(posedge i_clock) disable iff (!rst_n)
      s_attach_idle |=> !o_phy_enable[0];
  endproperty
  a_phy_detach: assert property (p_phy_detach)  // [RL12] [RL14]
    else $error("PHY 0 not disabled after detach");

  property p_gang_release;
    @(posedge i_clock) disable iff (!rst_n)
      (i_ganged_mode && |i_port_enable) |-> (&o_port_power_oc_pin_oe_n &&
        &o_port_power_oc_pin_pu_en);
  endproperty
  a_gang_release: assert property (p_gang_release)  // [RL4] [RL1]
    else $error("ganged mode did not release every port pin");

  property p_oc_ignored;
    @(posedge i_clock) disable iff (!rst_n)
      (!i_ganged_mode && !i_port_enable[4]) |=> !o_port_overcurrent[4];
  endproperty
  a_oc_ignored: assert property (p_oc_ignored)  // [RL2]
    else $error("overcurrent flagged on disabled port");

endmodule : hppr_top

/* File: tb/hppr_far_model.sv */
// Board-side model: power switches, current monitors, pull-ups and ROM clock pin
`timescale 1ns/1ps

module hppr_far_model
  import hppr_pkg::*;
(
  // Clock
  input  wire logic                    i_clock,
  // Port power pins from the block
  input  wire logic [NUM_DN_PORTS-1:0] i_pin_o,
  input  wire logic [NUM_DN_PORTS-1:0] i_pin_oe_n,
  input  wire logic [NUM_DN_PORTS-1:0] i_pin_pu_en,
  // Monitor commands from the bench
  input  wire logic [NUM_DN_PORTS-1:0] i_oc_low,
  input  wire logic                    i_gang_oc,
  // ROM clock pin
  input  wire logic                    i_clk_o,
  input  wire logic                    i_clk_oe_n,
  input  wire logic                    i_clk_ext,
  // Resolved levels
  output logic      [NUM_DN_PORTS-1:0] o_pin_lvl,
  output logic                         o_gang_lvl,
  output logic                         o_clk_lvl
);
  logic [NUM_DN_PORTS-1:0] last;

  // ****************************************
  // Wire resolution
  // ****************************************
  // An undriven pin with no monitor pulling it low and no pull-up shows the inverse of its last level, never a stale 0/1
  always_comb begin
    for (int k = 0; k < NUM_DN_PORTS; k++) begin
      if (!i_pin_oe_n[k]) o_pin_lvl[k] = i_pin_o[k];
      else if (i_oc_low[k]) o_pin_lvl[k] = 1'h0;
      else if (i_pin_pu_en[k]) o_pin_lvl[k] = 1'h1;
      else o_pin_lvl[k] = ~last[k];
    end
  end

  always_ff @(posedge i_clock) begin
    last <= o_pin_lvl;
  end

  // One gang monitor serves every port switch
  assign o_gang_lvl = ~i_gang_oc;
  // Clock pin is never floated; bench supplies the alternate level when released
  assign o_clk_lvl  = !i_clk_oe_n ? i_clk_o : i_clk_ext;
endmodule : hppr_far_model

/* File: tb/tb_top.sv */
// Directed testbench for the port power, role swap, ROM pin and attach block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end

module tb_top;
  import hppr_pkg::*;
  logic i_clock = 1'h0;
  logic i_nrst = 1'h0;
  logic [6:0] en = 7'h00, pin_lvl, oc_low = 7'h00, oc, oe_n, pu_en, pin_o;
  logic gang = 1'h0, gang_oc = 1'h0, gang_lvl, gang_flag, swap = 1'h0, ind, up0, up1;
  logic rom_dis = 1'h0, pdn = 1'h0, g_out = 1'h0, g_oe = 1'h0, ext = 1'h0;
  logic cs_n, rclk, rclk_oe_n, clk_lvl, gio4, dout;
  hppr_rom_t core = '{cs_n: 1'h0, clk: 1'h1, dout: 1'h1, active: 1'h1};
  logic [3:0] att = 4'h0, phy;
  int bad_count = 0;
  int cmp_count = 0;

  always #50 i_clock = ~i_clock;

  hppr_top dut (.i_clock(i_clock), .i_nrst(i_nrst), .i_port_enable(en),
    .i_ganged_mode(gang), .i_port_power_oc_pin(pin_lvl), .o_port_power_oc_pin(pin_o),
    .o_port_power_oc_pin_oe_n(oe_n), .o_port_power_oc_pin_pu_en(pu_en),
    .o_port_overcurrent(oc), .i_ganged_power_input(gang_lvl),
    .o_gang_overcurrent(gang_flag), .i_role_swap_input(swap),
    .o_role_swap_indicator(ind), .o_port0_upstream(up0), .o_port1_upstream(up1),
    .i_rom_disable(rom_dis), .i_power_down(pdn), .i_rom_core(core), .o_rom_cs_n(cs_n),
    .o_rom_clk(rclk), .o_rom_clk_oe_n(rclk_oe_n), .i_rom_clk_pin(clk_lvl),
    .i_gpio_out(g_out), .i_gpio_oe(g_oe), .o_general_io_four(gio4), .o_rom_dout(dout),
    .i_attach(att), .o_phy_enable(phy));

  hppr_far_model far (.i_clock(i_clock), .i_pin_o(pin_o), .i_pin_oe_n(oe_n),
    .i_pin_pu_en(pu_en), .i_oc_low(oc_low), .i_gang_oc(gang_oc), .i_clk_o(rclk),
    .i_clk_oe_n(rclk_oe_n), .i_clk_ext(ext), .o_pin_lvl(pin_lvl), .o_gang_lvl(gang_lvl),
    .o_clk_lvl(clk_lvl));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(negedge i_clock);
  endtask : tick

  task automatic give_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // Three edges through the synchroniser, one spare
  task automatic set_ports(input logic [6:0] e, input logic [6:0] l, input logic g);
    en = e;
    oc_low = l;
    gang = g;
    tick(4);
  endtask : set_ports

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    tick(6);
    `CHK("cs_n rst", 1'h1, cs_n)
    `CHK("rclk rst", 1'h0, rclk)
    `CHK("rclk_oe rst", 1'h0, rclk_oe_n)
    `CHK("ind rst", 1'h0, ind)
    i_nrst = 1'h1;
    tick(4);
    // Disabled port on a low pin must stay silent
    set_ports(7'h0F, 7'h14, 1'h0);
    `CHK("pu_en", 7'h0F, pu_en)
    `CHK("oe_n", 7'h0F, oe_n)
    `CHK("pin_o", 7'h00, pin_o)
    `CHK("pin_lvl", 7'h00, pin_lvl & 7'h70)
    `CHK("oc", 7'h04, oc)
    set_ports(7'h00, 7'h00, 1'h0);
    `CHK("oe_n off", 7'h00, oe_n)
    `CHK("oc off", 7'h00, oc)
    gang_oc = 1'h1;
    set_ports(7'h00, 7'h00, 1'h1);
    `CHK("gang idle", 1'h0, gang_flag)
    set_ports(7'h55, 7'h00, 1'h1);
    `CHK("gang oe_n", 7'h7F, oe_n)
    `CHK("gang flag", 1'h1, gang_flag)
    `CHK("gang oc", 7'h7F, oc)
    gang_oc = 1'h0;
    tick(4);
    `CHK("gang clr", 1'h0, gang_flag)
    for (int s = 1; s >= 0; s--) begin
      swap = s[0];
      tick(4);
      `CHK("ind", s[0], ind)
      `CHK("up0", ~s[0], up0)
      `CHK("up1", s[0], up1)
    end
    `CHK("cs_n on", 1'h0, cs_n)
    `CHK("rclk on", 1'h1, rclk)
    `CHK("dout on", 1'h1, dout)
    pdn = 1'h1;
    tick(2);
    `CHK("cs_n pdn", 1'h1, cs_n)
    `CHK("rclk pdn", 1'h0, rclk)
    pdn = 1'h0;
    rom_dis = 1'h1;
    g_out = 1'h1;
    g_oe = 1'h1;
    tick(2);
    `CHK("gpio drv", 1'h1, rclk)
    `CHK("gpio oe", 1'h0, rclk_oe_n)
    `CHK("cs_n dis", 1'h1, cs_n)
    `CHK("dout dis", 1'h0, dout)
    g_oe = 1'h0;
    for (int v = 1; v >= 0; v--) begin
      ext = v[0];
      tick(2);
      `CHK("gpio rel", 1'h1, rclk_oe_n)
      `CHK("gpio in", v[0], gio4)
    end
    for (int a = 0; a < 4; a++) begin
      att = 4'h1 << a;
      tick(4);
      `CHK("phy", 4'h1 << a, phy)
    end
    att = 4'hF;
    tick(4);
    `CHK("phy all", 4'hF, phy)
    att = 4'h0;
    tick(4);
    `CHK("phy none", 4'h0, phy)
    // Mid-run reset with swap and attach idle: release must show no false role or PHY edge
    i_nrst = 1'h0;
    tick(2);
    `CHK("rclk_oe rst2", 1'h0, rclk_oe_n)
    i_nrst = 1'h1;
    for (int c = 0; c < 6; c++) begin
      tick(1);
      `CHK("ind rel", 1'h0, ind)
      `CHK("phy rel", 4'h0, phy)
    end
    give_verdict();
  end

  // Tests take about 78 cycles; allow over fifteen times that
  initial begin
    #(1200 * 100);
    bad_count++;
    give_verdict();
  end
endmodule : tb_top
